/* rtl/tss_setups.sv */
// Setups block registers, checksum commit, lookups, key report and status
//
// Function
// R1 - Setups checked by checksum over setup bytes
// R2 - Host sends checksum low byte first
// R3 - Hop mode top bits, default recalibrate
// R4 - Scope pulse enabled per drive line bit
// R5 - Noise threshold index low nibble, default 0
// R6 - Burst delays six bits, defaults 24/30/36
// R7 - Awake index low nibble, default 15
// R8 - Noise integrator limit upper nibble, default 3
// R9 - Status pin active only for selected conditions
// R10 - Bit 7 debug use, exclusive, default 0
// R11 - Bit 6 key fault activates status
// R12 - Bit 5 touch change activates status
// R13 - Bit 3 checksum mismatch; bits 4,1 reserved
// R14 - Bit 2 mains sync fault activates status
// R15 - Bit 0 host watchdog, 2 s window
// R16 - Watchdog timeout gives 150 ms host reset
// R17 - Watchdog disarmed until first valid command
// R18 - Key report returns six flag bytes
// R19 - Byte is sense line, bit drive line
// R20 - Report byte 0 first, ascending
// R21 - Parameters given as indices via lookup
// R22 - Recal delay 0 infinite, half second steps
// R23 - Frequency offsets used without translation
// R24 - Checksum mismatch latched until good block
//
// The implementer's own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
module tss_setups #(
    parameter int WD_CYCLES = tss_pkg::WD_CYCLES,
    parameter int PULSE_CYCLES = tss_pkg::HOST_RST_CYCLES,
    parameter int NKEYS = tss_pkg::REPORT_BYTES * tss_pkg::KEYS_PER_BYTE
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic [tss_pkg::ADDR_W-1:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    input wire logic i_host_comm,
    input wire logic i_cmd_valid,
    input wire logic i_key_fault,
    input wire logic i_touch_change,
    input wire logic i_mains_fault,
    input wire logic i_debug_level,
    input wire logic i_burst_active,
    input wire logic [2:0] i_burst_line,
    input wire logic i_report_start,
    input wire logic [NKEYS-1:0] i_touch_flags,
    input wire logic [7:0] i_neg_recal_delay,
    input wire logic [7:0] i_freq_offset_one,
    input wire logic [7:0] i_freq_offset_two,
    output logic [1:0] o_hop_mode,
    output logic o_recal_after_hop,
    output logic [5:0] o_noise_level_limit,
    output logic [5:0] o_burst_delay_a,
    output logic [5:0] o_burst_delay_b,
    output logic [5:0] o_burst_delay_c,
    output logic [3:0] o_integ_limit,
    output logic [7:0] o_awake_tenths,
    output logic o_scope_sync,
    output logic o_nrd_infinite,
    output logic [7:0] o_nrd_half_secs,
    output logic [7:0] o_freq_offset_one,
    output logic [7:0] o_freq_offset_two,
    output logic o_checksum_fault,
    output logic o_rep_valid,
    output logic [7:0] o_rep_byte,
    output logic o_status_n,
    output logic o_host_reset
);
    localparam int NB = tss_pkg::SETUP_BYTES;
    localparam int NR = tss_pkg::REPORT_BYTES;

    typedef struct packed {
        logic [NB-1:0][7:0] stage;
        logic [NB-1:0][7:0] act;
        logic [7:0] csum_lo;
        logic mismatch;
        logic [7:0] rdata;
        tss_pkg::tss_rep_t rstate;
        logic [2:0] rcnt;
        logic [NKEYS-1:0] rflags;
        logic [7:0] rbyte;
        logic rvalid;
        logic scope;
        logic [5:0] noise_cnt;
        logic [7:0] awake;
        logic nrd_inf;
        logic [7:0] nrd_half;
        logic [7:0] fo_one;
        logic [7:0] fo_two;
    } tss_main_st_t;

    tss_main_st_t st;
    tss_main_st_t next_st;
    logic [15:0] calc_crc;
    logic [15:0] rx_crc;
    logic crc_ok;
    logic commit;
    logic wd_armed;

    // ==========================================================
    // Lookups from index to parameter value
    function automatic logic [5:0] noise_counts(input logic [3:0] idx);
        return tss_pkg::NOISE_BASE + 6'(tss_pkg::NOISE_STEP * idx);
    endfunction

    // Awake time in tenths of a second
    function automatic logic [7:0] awake_tenths(input logic [3:0] idx);
        logic [7:0] v;
        case (idx)
            4'h0: v = 8'h01;
            4'h1: v = 8'h02;
            4'h2: v = 8'h03;
            4'h3: v = 8'h05;
            4'h4: v = 8'h07;
            4'h5: v = 8'h0A;
            4'h6: v = 8'h0F;
            4'h7: v = 8'h14;
            4'h8: v = 8'h20;
            4'h9: v = 8'h2D;
            4'hA: v = 8'h3C;
            4'hB: v = 8'h5A;
            4'hC: v = 8'h7B;
            4'hD: v = 8'h96;
            4'hE: v = 8'hBE;
            default: v = 8'hFE;
        endcase
        return v;
    endfunction

    // Write mask of each setup byte; reserved bits never store
    function automatic logic [7:0] byte_mask(input logic [3:0] off);
        logic [7:0] m;
        case (off)
            tss_pkg::OFF_HOP_NOISE: m = tss_pkg::HOP_NOISE_MASK;
            tss_pkg::OFF_BURST_A: m = tss_pkg::BURST_MASK;
            tss_pkg::OFF_BURST_B: m = tss_pkg::BURST_MASK;
            tss_pkg::OFF_BURST_C: m = tss_pkg::BURST_MASK;
            tss_pkg::OFF_STATUS_SEL: m = tss_pkg::SEL_MASK;
            default: m = 8'hFF;
        endcase
        return m;
    endfunction

    // ==========================================================
    // Checksum over the staged setup bytes only
    tss_crc16 #(
        .NBYTES(NB),
        .POLY(tss_pkg::CRC_POLY),
        .INIT(tss_pkg::CRC_INIT)
    ) u_crc (
        .i_data(st.stage),
        .o_crc(calc_crc)
    );

    assign rx_crc = {i_wdata, st.csum_lo}; // R2
    assign crc_ok = (rx_crc == calc_crc); // R1
    assign commit = i_wr && (i_addr == tss_pkg::OFF_CSUM_HI);

    // ==========================================================
    // Next state
    always_comb begin
        next_st = st;
        next_st.rdata = 8'h00;
        // Setup bytes only take effect once a good checksum commits them
        if (i_wr && i_addr < tss_pkg::ADDR_W'(NB)) begin
            next_st.stage[i_addr[2:0]] = i_wdata & byte_mask(i_addr); // R13
        end
        if (i_wr && i_addr == tss_pkg::OFF_CSUM_LO) begin
            next_st.csum_lo = i_wdata;
        end
        if (commit) begin
            if (crc_ok) begin
                next_st.act = st.stage; // R1
                next_st.mismatch = 1'b0; // R24
            end else begin
                next_st.mismatch = 1'b1; // R24
            end
        end
        if (i_rd) begin
            if (i_addr < tss_pkg::ADDR_W'(NB)) begin
                next_st.rdata = st.act[i_addr[2:0]];
            end else if (i_addr == tss_pkg::OFF_STATE) begin
                next_st.rdata = {5'h00, o_host_reset, wd_armed, st.mismatch};
            end
        end
        // Key report: byte index is the sense line, bit the drive line
        case (st.rstate)
            tss_pkg::REP_IDLE: begin
                next_st.rvalid = 1'b0;
                if (i_report_start) begin
                    next_st.rflags = i_touch_flags; // R18
                    next_st.rbyte = i_touch_flags[7:0]; // R20
                    next_st.rvalid = 1'b1;
                    next_st.rcnt = 3'h1;
                    next_st.rstate = tss_pkg::REP_SEND;
                end
            end
            tss_pkg::REP_SEND: begin
                if (st.rcnt == 3'(NR)) begin
                    next_st.rvalid = 1'b0;
                    next_st.rcnt = 3'h0;
                    next_st.rstate = tss_pkg::REP_IDLE;
                end else begin
                    next_st.rbyte = st.rflags[8*st.rcnt +: 8]; // R19
                    next_st.rcnt = st.rcnt + 3'h1; // R20
                end
            end
            default: begin
                next_st.rstate = tss_pkg::REP_IDLE;
                next_st.rvalid = 1'b0;
            end
        endcase
        next_st.scope = i_burst_active
            && st.act[tss_pkg::OFF_SCOPE[2:0]][i_burst_line]; // R4
        next_st.noise_cnt = noise_counts(st.act[tss_pkg::OFF_HOP_NOISE[2:0]][3:0]); // R5
        next_st.awake = awake_tenths(st.act[tss_pkg::OFF_INTEG_AWAKE[2:0]][3:0]); // R7
        next_st.nrd_inf = (i_neg_recal_delay == 8'h00); // R22
        next_st.nrd_half = i_neg_recal_delay; // R22
        next_st.fo_one = i_freq_offset_one; // R23
        next_st.fo_two = i_freq_offset_two; // R23
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            st <= '0;
            st.stage <= tss_pkg::SETUP_RST;
            st.act <= tss_pkg::SETUP_RST; // R6
            st.rstate <= tss_pkg::REP_IDLE;
        end else if (i_ce) begin
            st <= next_st;
        end
    end

    // ==========================================================
    // Status pin and host watchdog
    tss_status_pin #(
        .WD_CYCLES(WD_CYCLES),
        .PULSE_CYCLES(PULSE_CYCLES)
    ) u_status (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_ce(i_ce),
        .i_sel(st.act[tss_pkg::OFF_STATUS_SEL[2:0]]),
        .i_key_fault(i_key_fault),
        .i_touch_change(i_touch_change),
        .i_csum_fault(st.mismatch),
        .i_mains_fault(i_mains_fault),
        .i_debug_level(i_debug_level),
        .i_host_comm(i_host_comm || i_wr || i_rd),
        .i_cmd_valid(i_cmd_valid),
        .o_status_n(o_status_n),
        .o_wd_armed(wd_armed),
        .o_host_reset(o_host_reset)
    );

    // ==========================================================
    // Outputs
    assign o_rdata = st.rdata;
    assign o_hop_mode = st.act[tss_pkg::OFF_HOP_NOISE[2:0]][tss_pkg::HOP_LSB +: 2]; // R3
    assign o_recal_after_hop = (o_hop_mode == tss_pkg::HOP_RECAL); // R3
    assign o_noise_level_limit = st.noise_cnt; // R21
    assign o_burst_delay_a = st.act[tss_pkg::OFF_BURST_A[2:0]][5:0]; // R6
    assign o_burst_delay_b = st.act[tss_pkg::OFF_BURST_B[2:0]][5:0]; // R6
    assign o_burst_delay_c = st.act[tss_pkg::OFF_BURST_C[2:0]][5:0]; // R6
    assign o_integ_limit = st.act[tss_pkg::OFF_INTEG_AWAKE[2:0]][tss_pkg::INTEG_LSB +: 4]; // R8
    assign o_awake_tenths = st.awake;
    assign o_scope_sync = st.scope;
    assign o_nrd_infinite = st.nrd_inf;
    assign o_nrd_half_secs = st.nrd_half;
    assign o_freq_offset_one = st.fo_one;
    assign o_freq_offset_two = st.fo_two;
    assign o_checksum_fault = st.mismatch;
    assign o_rep_valid = st.rvalid;
    assign o_rep_byte = st.rbyte;

    // ==========================================================
    // Checks
    a_commit_good: assert property (@(posedge i_clk) disable iff (i_rst) // R1
        i_ce && commit && crc_ok |=> st.act == $past(st.stage) && !st.mismatch)
        else $error("good checksum did not commit setups");
    a_commit_bad: assert property (@(posedge i_clk) disable iff (i_rst) // R24
        i_ce && commit && !crc_ok |=> st.act == $past(st.act) && st.mismatch)
        else $error("bad checksum changed setups or missed flag");
    a_mismatch_held: assert property (@(posedge i_clk) disable iff (i_rst) // R24
        st.mismatch && !(i_ce && commit) |=> st.mismatch)
        else $error("checksum mismatch dropped without good block");
    a_report_len: assert property (@(posedge i_clk) disable iff (i_rst || !i_ce) // R18
        $rose(o_rep_valid) |-> o_rep_valid [*6] ##1 !o_rep_valid)
        else $error("key report not six bytes");
    a_report_first: assert property (@(posedge i_clk) disable iff (i_rst || !i_ce) // R20
        st.rstate == tss_pkg::REP_IDLE && i_report_start
        |=> o_rep_byte == $past(i_touch_flags[7:0]) ##1 o_rep_byte == st.rflags[15:8])
        else $error("key report order wrong");
    a_scope_gate: assert property (@(posedge i_clk) disable iff (i_rst || !i_ce) // R4
        !i_burst_active |=> !o_scope_sync)
        else $error("scope pulse outside burst");
    a_recal_hop: assert property (@(posedge i_clk) disable iff (i_rst) // R3
        o_recal_after_hop == (st.act[0][7:6] == 2'h1))
        else $error("hop mode decode wrong");
    a_nrd_inf: assert property (@(posedge i_clk) disable iff (i_rst || !i_ce) // R22
        i_neg_recal_delay == 8'h00 |=> o_nrd_infinite && o_nrd_half_secs == 8'h00)
        else $error("zero recal delay not infinite");
    a_rdata_idle: assert property (@(posedge i_clk) disable iff (i_rst || !i_ce)
        !i_rd |=> o_rdata == 8'h00)
        else $error("read data outside read answer");
endmodule
`default_nettype wire

/* inc/tss_pkg.sv */
// Shared constants and types of the touch setups and status logic
package tss_pkg;
    // ==========================================================
    // Timing
    localparam int CLK_HZ = 40_000_000;
    localparam int WD_WINDOW_MS = 2000;
    localparam int HOST_RST_MS = 150;
    localparam int WD_CYCLES = CLK_HZ / 1000 * WD_WINDOW_MS;
    localparam int HOST_RST_CYCLES = CLK_HZ / 1000 * HOST_RST_MS;
    // ==========================================================
    // Sizes
    localparam int ADDR_W = 4;
    localparam int SETUP_BYTES = 7;
    localparam int REPORT_BYTES = 6;
    localparam int KEYS_PER_BYTE = 8;
    // ==========================================================
    // Register offsets
    localparam logic [3:0] OFF_HOP_NOISE = 4'h0;
    localparam logic [3:0] OFF_BURST_A = 4'h1;
    localparam logic [3:0] OFF_BURST_B = 4'h2;
    localparam logic [3:0] OFF_BURST_C = 4'h3;
    localparam logic [3:0] OFF_INTEG_AWAKE = 4'h4;
    localparam logic [3:0] OFF_SCOPE = 4'h5;
    localparam logic [3:0] OFF_STATUS_SEL = 4'h6;
    localparam logic [3:0] OFF_CSUM_LO = 4'h7;
    localparam logic [3:0] OFF_CSUM_HI = 4'h8;
    localparam logic [3:0] OFF_STATE = 4'h9;
    // ==========================================================
    // Fields
    localparam int HOP_LSB = 6;
    localparam int INTEG_LSB = 4;
    localparam logic [7:0] BURST_MASK = 8'h3F;
    localparam logic [7:0] NIBBLE_MASK = 8'h0F;
    localparam logic [7:0] HOP_NOISE_MASK = 8'hCF;
    localparam logic [7:0] SEL_MASK = 8'hED;
    localparam int SEL_DEBUG = 7;
    localparam int SEL_KEY = 6;
    localparam int SEL_TOUCH = 5;
    localparam int SEL_CSUM = 3;
    localparam int SEL_MAINS = 2;
    localparam int SEL_WD = 0;
    localparam logic [1:0] HOP_RECAL = 2'h1;
    localparam logic [5:0] NOISE_BASE = 6'h05;
    localparam logic [5:0] NOISE_STEP = 6'h03;
    // ==========================================================
    // Values after reset, byte 0 in the low lane
    localparam logic [7:0] RST_HOP_NOISE = 8'h40;
    localparam logic [7:0] RST_BURST_A = 8'h18;
    localparam logic [7:0] RST_BURST_B = 8'h1E;
    localparam logic [7:0] RST_BURST_C = 8'h24;
    localparam logic [7:0] RST_INTEG_AWAKE = 8'h3F;
    localparam logic [7:0] RST_SCOPE = 8'h00;
    localparam logic [7:0] RST_STATUS_SEL = 8'h20;
    localparam logic [SETUP_BYTES-1:0][7:0] SETUP_RST = {RST_STATUS_SEL, RST_SCOPE,
        RST_INTEG_AWAKE, RST_BURST_C, RST_BURST_B, RST_BURST_A, RST_HOP_NOISE};
    // ==========================================================
    // Checksum
    localparam logic [15:0] CRC_POLY = 16'h8005;
    localparam logic [15:0] CRC_INIT = 16'h0000;
    // ==========================================================
    // Key report sequencer
    typedef enum logic {REP_IDLE, REP_SEND} tss_rep_t;
endpackage

/* rtl/tss_crc16.sv */
// Combinational 16-bit checksum over a packed block of bytes
`timescale 1ns/10ps
`default_nettype none
module tss_crc16 #(
    parameter int NBYTES = tss_pkg::SETUP_BYTES,
    parameter logic [15:0] POLY = tss_pkg::CRC_POLY,
    parameter logic [15:0] INIT = tss_pkg::CRC_INIT
) (
    input wire logic [8*NBYTES-1:0] i_data,
    output logic [15:0] o_crc
);
    // ==========================================================
    // Byte step, most significant bit first
    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        logic fb;
        r = c;
        for (int i = 7; i >= 0; i--) begin
            fb = r[15] ^ d[i];
            r = {r[14:0], 1'b0};
            if (fb) begin
                r = r ^ POLY;
            end
        end
        return r;
    endfunction

    // Byte 0 enters first
    always_comb begin
        o_crc = INIT;
        for (int k = 0; k < NBYTES; k++) begin
            o_crc = crc_step(o_crc, i_data[8*k +: 8]);
        end
    end
endmodule
`default_nettype wire

/* rtl/tss_status_pin.sv */
// Status pin condition selection and host watchdog
`timescale 1ns/10ps
`default_nettype none
module tss_status_pin #(
    parameter int WD_CYCLES = tss_pkg::WD_CYCLES,
    parameter int PULSE_CYCLES = tss_pkg::HOST_RST_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic [7:0] i_sel,
    input wire logic i_key_fault,
    input wire logic i_touch_change,
    input wire logic i_csum_fault,
    input wire logic i_mains_fault,
    input wire logic i_debug_level,
    input wire logic i_host_comm,
    input wire logic i_cmd_valid,
    output logic o_status_n,
    output logic o_wd_armed,
    output logic o_host_reset
);
    localparam int WD_W = $clog2(WD_CYCLES + 1);
    localparam int PL_W = $clog2(PULSE_CYCLES + 1);

    typedef struct packed {
        logic armed;
        logic pulsing;
        logic [WD_W-1:0] wcnt;
        logic [PL_W-1:0] pcnt;
        logic status_n;
    } tss_wd_st_t;

    tss_wd_st_t st;
    tss_wd_st_t next_st;
    logic active;

    // ==========================================================
    // Next state
    always_comb begin
        next_st = st;
        if (i_cmd_valid) begin
            next_st.armed = 1'b1; // R17
        end
        if (st.armed && i_sel[tss_pkg::SEL_WD] && !st.pulsing) begin
            if (i_host_comm) begin
                next_st.wcnt = '0;
            end else if (st.wcnt == WD_W'(WD_CYCLES - 1)) begin
                next_st.wcnt = '0; // R15
                next_st.pulsing = 1'b1;
                next_st.pcnt = '0;
            end else begin
                next_st.wcnt = st.wcnt + 1'b1;
            end
        end else if (!st.pulsing) begin
            next_st.wcnt = '0;
        end
        if (st.pulsing) begin
            if (st.pcnt == PL_W'(PULSE_CYCLES - 1)) begin
                next_st.pulsing = 1'b0; // R16
            end else begin
                next_st.pcnt = st.pcnt + 1'b1;
            end
        end
        active = (i_sel[tss_pkg::SEL_KEY] && i_key_fault) // R11
            || (i_sel[tss_pkg::SEL_TOUCH] && i_touch_change) // R12
            || (i_sel[tss_pkg::SEL_CSUM] && i_csum_fault) // R13
            || (i_sel[tss_pkg::SEL_MAINS] && i_mains_fault) // R14
            || st.pulsing; // R16
        // Debug use owns the pin; other selections are ignored then
        if (i_sel[tss_pkg::SEL_DEBUG]) begin
            next_st.status_n = ~i_debug_level; // R10
        end else begin
            next_st.status_n = ~active; // R9
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            st <= '0;
            st.status_n <= 1'b1;
        end else if (i_ce) begin
            st <= next_st;
        end
    end

    assign o_status_n = st.status_n;
    assign o_wd_armed = st.armed;
    assign o_host_reset = st.pulsing;

    // ==========================================================
    // Checks
    a_wd_disarmed: assert property (@(posedge i_clk) disable iff (i_rst) // R17
        !st.armed |-> !st.pulsing && st.wcnt == '0)
        else $error("watchdog ran while disarmed");
    a_pulse_drives_pin: assert property (@(posedge i_clk) disable iff (i_rst || !i_ce) // R16
        st.pulsing && !i_sel[tss_pkg::SEL_DEBUG] |=> !o_status_n)
        else $error("host reset pulse not on status pin");
    a_sel_gates_pin: assert property (@(posedge i_clk) disable iff (i_rst || !i_ce) // R9
        i_sel == 8'h00 && !st.pulsing |=> o_status_n)
        else $error("status active with nothing selected");
    a_debug_follow: assert property (@(posedge i_clk) disable iff (i_rst || !i_ce) // R10
        i_sel[tss_pkg::SEL_DEBUG] |=> o_status_n == !$past(i_debug_level))
        else $error("debug level not on status pin");
endmodule
`default_nettype wire

/* dv/tss_host_model.sv */
// Host model on the register port of the setups block
`timescale 1ns/10ps
`default_nettype none
module tss_host_model (
    input wire logic i_clk,
    input wire logic [7:0] i_rdata,
    output logic [3:0] o_addr = 4'h0,
    output logic [7:0] o_wdata = 8'h00,
    output logic o_wr = 1'b0,
    output logic o_rd = 1'b0,
    output logic o_host_comm = 1'b0,
    output logic o_cmd_valid = 1'b0
);
    // ====
    // Released lines show the inverse
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clk);
        o_addr <= a;
        o_wdata <= d;
        o_wr <= 1'b1;
        @(posedge i_clk);
        o_wr <= 1'b0;
        o_addr <= ~a;
        o_wdata <= ~d;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge i_clk);
        o_addr <= a;
        o_rd <= 1'b1;
        @(posedge i_clk);
        o_rd <= 1'b0;
        o_addr <= ~a;
        #1 d = i_rdata;
    endtask
    // ====
    // Byte 0 first, msb first
    function automatic logic [15:0] crc(input logic [6:0][7:0] b);
        logic [15:0] c;
        c = 16'h0000;
        for (int i = 0; i < 7; i++) begin
            for (int k = 7; k >= 0; k--) begin
                c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i][k]) ? tss_pkg::CRC_POLY : 16'h0000);
            end
        end
        return c;
    endfunction
    task automatic commit(input logic [6:0][7:0] b, input logic bad);
        logic [15:0] c;
        c = crc(b) ^ {15'h0000, bad};
        for (int i = 0; i < 7; i++) begin
            wr(4'(i), b[i]);
        end
        wr(tss_pkg::OFF_CSUM_LO, c[7:0]);
        wr(tss_pkg::OFF_CSUM_HI, c[15:8]);
    endtask
    task automatic cmd();
        @(posedge i_clk);
        o_host_comm <= 1'b1;
        o_cmd_valid <= 1'b1;
        @(posedge i_clk);
        o_host_comm <= 1'b0;
        o_cmd_valid <= 1'b0;
    endtask
endmodule
`default_nettype wire

/* dv/tb_top.sv */
// Testbench of the setups and status block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic i_clk = 1'b0, i_rst = 1'b1, i_ce = 1'b1, i_wr, i_rd, i_host_comm, i_cmd_valid;
    logic i_key_fault = 0, i_touch_change = 0, i_mains_fault = 0, i_debug_level = 0;
    logic i_burst_active = 0, i_report_start = 0;
    logic [2:0] i_burst_line = 3'h0;
    logic [3:0] i_addr;
    logic [7:0] i_wdata, o_rdata, o_awake_tenths, o_nrd_half_secs, o_rep_byte;
    logic [7:0] i_neg_recal_delay = 8'h01, i_freq_offset_one = 8'h00, i_freq_offset_two = 8'h00;
    logic [7:0] o_freq_offset_one, o_freq_offset_two;
    logic [47:0] i_touch_flags = 48'h0;
    logic [1:0] o_hop_mode;
    logic [5:0] o_noise_level_limit, o_burst_delay_a, o_burst_delay_b, o_burst_delay_c;
    logic [3:0] o_integ_limit;
    logic o_recal_after_hop, o_scope_sync, o_nrd_infinite, o_checksum_fault;
    logic o_rep_valid, o_status_n, o_host_reset;
    int fail_count = 0, n_tests = 0;
    always #12.5 i_clk = ~i_clk;
    tss_setups #(.WD_CYCLES(40), .PULSE_CYCLES(6)) uut (.*);
    tss_host_model host (.i_clk, .i_rdata(o_rdata), .o_addr(i_addr), .o_wdata(i_wdata),
        .o_wr(i_wr), .o_rd(i_rd), .o_host_comm(i_host_comm), .o_cmd_valid(i_cmd_valid));
    // ====
    // Helpers
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    task automatic wait_hr(input logic v, output int n);
        for (n = 0; o_host_reset !== v; n++) begin
            if (n == 200) begin
                fail_count++;
                final_report();
            end
            tick(1);
        end
    endtask
    task automatic setup(input logic [7:0] sel, input logic [7:0] sc, input logic bad);
        host.commit({sel, sc, 8'h5A, 8'h02, 8'h01, 8'h3F, 8'hCF}, bad);
        tick(2);
    endtask
    // ====
    // Scenarios
    task automatic t_defaults();
        logic [6:0][7:0] e = tss_pkg::SETUP_RST;
        logic [7:0] d;
        for (int i = 0; i < 7; i++) begin
            host.rd(4'(i), d);
            chk("rst", d, e[i]);
        end
        host.rd(4'hF, d);
        chk("unmap", d, 8'h00);
        chk("hop", {o_hop_mode, o_recal_after_hop}, 3'h3);
        chk("noise", o_noise_level_limit, 6'h05);
        chk("bursts", {o_burst_delay_a, o_burst_delay_b, o_burst_delay_c}, 18'h187A4);
        chk("awake", {o_integ_limit, o_awake_tenths}, 12'h3FE);
        $display("defaults done");
    endtask
    task automatic t_setups();
        logic [7:0] d;
        setup(8'h08, 8'h04, 1'b0);
        chk("hop", {o_hop_mode, o_recal_after_hop}, 3'h6);
        chk("noise", o_noise_level_limit, 6'h32);
        chk("burst a", o_burst_delay_a, 6'h3F);
        chk("awake", {o_integ_limit, o_awake_tenths}, 12'h53C);
        chk("good", {o_checksum_fault, o_status_n}, 2'h1);
        @(posedge i_clk);
        i_burst_active <= 1'b1;
        i_burst_line <= 3'h2;
        tick(2);
        chk("scope on", o_scope_sync, 1'b1);
        i_burst_line <= 3'h3;
        tick(2);
        chk("scope off", o_scope_sync, 1'b0);
        setup(8'h28, 8'h04, 1'b1);
        chk("bad", {o_checksum_fault, o_status_n}, 2'h2);
        host.rd(tss_pkg::OFF_STATUS_SEL, d);
        chk("kept", d, 8'h08);
        tick(20);
        chk("held", o_checksum_fault, 1'b1);
        setup(8'h08, 8'h04, 1'b0);
        chk("clr", {o_checksum_fault, o_status_n}, 2'h1);
        $display("setups done");
    endtask
    task automatic t_status();
        logic [2:0][7:0] sel = {8'h40, 8'h20, 8'h04};
        for (int j = 0; j < 3; j++) begin
            setup(sel[j], 8'h00, 1'b0);
            {i_key_fault, i_touch_change, i_mains_fault} <= ~(3'h1 << j);
            tick(3);
            chk("unsel", o_status_n, 1'b1);
            {i_key_fault, i_touch_change, i_mains_fault} <= 3'h7;
            tick(3);
            chk("sel", o_status_n, 1'b0);
        end
        setup(8'h80, 8'h00, 1'b0);
        i_debug_level <= 1'b1;
        tick(3);
        chk("dbg hi", o_status_n, 1'b0);
        i_debug_level <= 1'b0;
        tick(3);
        chk("dbg lo", o_status_n, 1'b1);
        {i_key_fault, i_touch_change, i_mains_fault} <= 3'h0;
        $display("status done");
    endtask
    task automatic t_watchdog();
        logic hr = 1'b0;
        int n;
        setup(8'h01, 8'h00, 1'b0);
        repeat (60) begin
            tick(1);
            hr = hr | o_host_reset;
        end
        chk("disarmed", {hr, o_status_n}, 2'h1);
        host.cmd();
        wait_hr(1'b1, n);
        chk("window", n >= 36 && n <= 42, 1'b1);
        tick(2);
        chk("pin", o_status_n, 1'b0);
        wait_hr(1'b0, n);
        chk("len", n + 2, 16'd6);
        $display("watchdog done");
    endtask
    task automatic t_report();
        @(posedge i_clk);
        i_touch_flags <= 48'hA50F3C817E12;
        i_report_start <= 1'b1;
        @(posedge i_clk);
        i_report_start <= 1'b0;
        for (int j = 0; j < 6; j++) begin
            #1;
            chk("rep", {o_rep_valid, o_rep_byte}, {1'b1, i_touch_flags[8*j+:8]});
            @(posedge i_clk);
            i_report_start <= (j == 1);
        end
        tick(1);
        chk("rep end", o_rep_valid, 1'b0);
        $display("report done");
    endtask
    task automatic t_params();
        i_neg_recal_delay <= 8'h00;
        i_freq_offset_one <= 8'hA5;
        i_freq_offset_two <= 8'hFF;
        tick(2);
        chk("nrd inf", o_nrd_infinite, 1'b1);
        chk("offsets", {o_freq_offset_one, o_freq_offset_two}, 16'hA5FF);
        i_neg_recal_delay <= 8'hFE;
        tick(2);
        chk("nrd max", {o_nrd_infinite, o_nrd_half_secs}, 9'h0FE);
        $display("params done");
    endtask
    initial begin
        repeat (16) @(posedge i_clk);
        i_rst <= 1'b0;
        tick(1);
        t_defaults();
        t_setups();
        t_status();
        t_report();
        t_params();
        t_watchdog();
        final_report();
    end
endmodule
`default_nettype wire
